// File: rtl/aac_frame_codec.sv
// adapter side codec for object access (all) and error notification frames
`timescale 1ns/10ps
`default_nettype none
`include "aac_consts.svh"

module aac_frame_codec (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_ERR,
    output logic RX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire logic [15:0] ADAPTER_RESULT,
    input wire logic PROP_WR,
    input wire logic [1:0] PROP_IDX,
    input wire logic [7:0] PROP_DATA,
    output aac_pkg::aac_byte_s EQ_BYTE,
    output logic EQ_COMMIT,
    output logic EQ_ABORT,
    output logic [23:0] OBJ_CODE,
    output logic REQ_DONE,
    output logic [3:0] DIRTY
);
    import aac_pkg::*;

    // ==========================================================
    // receive state
    aac_rx_e rx_state_r;          // parser state
    logic [15:0] ft_r;            // received frame type
    logic [7:0] cn_r;             // received command number
    logic [7:0] fn_r;             // received function number
    logic [15:0] dl_r;            // received data length
    logic [15:0] cnt_r;           // body byte counter
    logic [7:0] acc_r;            // access code
    logic [23:0] obj_r;           // object code being collected
    logic eq_seen_r;              // equipment bytes forwarded this frame
    logic [7:0] rx_chk;           // expected check byte

    // ==========================================================
    // property store and transmit state
    logic [7:0] prop_val_r [`AAC_NPROP];  // adapter-owned values
    logic [7:0] snap_val_r [`AAC_NPROP];  // values frozen for a response
    logic [3:0] dirty_r;                  // written from outside
    logic [3:0] snap_dirty_r;             // dirty set frozen for a response
    aac_rsp_s rsp_r;                      // frame being sent
    logic tx_busy_r;
    logic tx_valid_r;
    logic [7:0] tx_data_r;
    logic [4:0] tx_idx_r;                 // next byte position
    logic [4:0] total_r;                  // bytes in the frame
    logic [7:0] tx_chk;

    // ==========================================================
    // receive decode
    wire rx_take = RX_VALID && RX_READY;
    wire rx_start = rx_take && rx_state_r == RX_HUNT && RX_DATA == `AAC_START;
    wire rx_sum_en = rx_take && rx_state_r != RX_HUNT && rx_state_r != RX_CHK;
    wire rx_abort = RX_ERR && rx_state_r != RX_HUNT;
    wire chk_end = rx_take && rx_state_r == RX_CHK;
    wire frame_end = chk_end || rx_abort;
    wire [15:0] dl_now = {dl_r[15:8], RX_DATA};
    wire body_last = cnt_r == dl_r - 16'h0001;
    wire chk_bad = RX_DATA != rx_chk;
    wire is_cmd = ft_r == `AAC_FT_CMD && cn_r == `AAC_CN_REQ;
    wire fmt_bad = dl_r < `AAC_BODY_MIN
        || (acc_r == `AAC_ACC_RD && dl_r != `AAC_BODY_MIN);
    wire eq_fwd = rx_take && rx_state_r == RX_BODY && cnt_r >= `AAC_BODY_MIN
        && acc_r == `AAC_ACC_WR;

    // error precedence: link fault, check byte, command, format
    wire [7:0] err_code = rx_abort ? `AAC_ERR_OTHER :
        chk_bad ? `AAC_ERR_CHK :
        !is_cmd ? `AAC_ERR_CMD :
        `AAC_ERR_FMT;
    wire good_req = chk_end && !chk_bad && is_cmd && !fmt_bad;
    wire err_go = frame_end && !good_req;

    // result: reserved access rejected, undefined user result -> other
    wire res_def = ADAPTER_RESULT == `AAC_RES_OK || ADAPTER_RESULT == `AAC_RES_OK_NET
        || ADAPTER_RESULT == `AAC_RES_REJ || ADAPTER_RESULT == `AAC_RES_ST_UNCONF
        || ADAPTER_RESULT == `AAC_RES_ST_STANDBY || ADAPTER_RESULT == `AAC_RES_ST_CONSTR
        || ADAPTER_RESULT == `AAC_RES_ST_ERRSTOP || ADAPTER_RESULT == `AAC_RES_OTHER;
    wire acc_known = acc_r == `AAC_ACC_RD || acc_r == `AAC_ACC_WR;
    wire [15:0] result = !acc_known ? `AAC_RES_REJ :
        res_def ? ADAPTER_RESULT : `AAC_RES_OTHER;
    wire accepted = result == `AAC_RES_OK || result == `AAC_RES_OK_NET;
    wire incl = accepted && acc_r == `AAC_ACC_RD;

    // ==========================================================
    // receive parser
    always_ff @(posedge MCLK) begin
        if (SYS_RST || rx_abort) begin
            rx_state_r <= RX_HUNT;
        end else if (rx_take) begin
            case (rx_state_r)
                RX_HUNT: begin
                    if (RX_DATA == `AAC_START) begin
                        rx_state_r <= RX_FT_HI;
                    end
                end
                RX_FT_HI: rx_state_r <= RX_FT_LO;
                RX_FT_LO: rx_state_r <= RX_CN;
                RX_CN: rx_state_r <= RX_FN;
                RX_FN: rx_state_r <= RX_DL_HI;
                RX_DL_HI: rx_state_r <= RX_DL_LO;
                RX_DL_LO: begin
                    rx_state_r <= (dl_now == 16'h0000) ? RX_CHK : RX_BODY;
                end
                RX_BODY: begin
                    if (body_last) begin
                        rx_state_r <= RX_CHK;
                    end
                end
                default: rx_state_r <= RX_HUNT;
            endcase
        end
    end

    // ==========================================================
    // header and body field capture
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ft_r <= 16'h0000;
            cn_r <= 8'h00;
            fn_r <= 8'h00;
            dl_r <= 16'h0000;
            cnt_r <= 16'h0000;
            acc_r <= 8'h00;
            obj_r <= 24'h000000;
        end else if (rx_take) begin
            if (rx_state_r == RX_FT_HI) ft_r[15:8] <= RX_DATA;
            if (rx_state_r == RX_FT_LO) ft_r[7:0] <= RX_DATA;
            if (rx_state_r == RX_CN) cn_r <= RX_DATA;
            if (rx_state_r == RX_FN) fn_r <= RX_DATA;    // kept for echo
            if (rx_state_r == RX_DL_HI) dl_r[15:8] <= RX_DATA;
            if (rx_state_r == RX_DL_LO) begin
                dl_r[7:0] <= RX_DATA;
                cnt_r <= 16'h0000;
                acc_r <= 8'h00;
            end
            if (rx_state_r == RX_BODY) begin
                cnt_r <= cnt_r + 16'h0001;
                if (cnt_r == `AAC_BODY_ACC) acc_r <= RX_DATA;
                if (cnt_r != `AAC_BODY_ACC && cnt_r <= `AAC_BODY_OBJ_LAST) begin
                    obj_r <= {obj_r[15:0], RX_DATA};
                end
            end
        end
    end

    // receive check byte over frame type through last data byte
    aac_check_acc u_rx_chk (
        .clk(MCLK),
        .rst(SYS_RST),
        .clr(rx_start),
        .en(rx_sum_en),
        .data(RX_DATA),
        .chk(rx_chk)
    );

    // ==========================================================
    // equipment-owned values out; commit only on a clean frame
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            EQ_BYTE <= '0;
            EQ_COMMIT <= 1'b0;
            EQ_ABORT <= 1'b0;
            eq_seen_r <= 1'b0;
            OBJ_CODE <= 24'h000000;
            REQ_DONE <= 1'b0;
        end else begin
            EQ_BYTE.valid <= eq_fwd;
            if (eq_fwd) EQ_BYTE.data <= RX_DATA;
            EQ_COMMIT <= good_req && acc_r == `AAC_ACC_WR && accepted;
            EQ_ABORT <= frame_end && eq_seen_r
                && !(good_req && acc_r == `AAC_ACC_WR && accepted);
            if (rx_start || frame_end) begin
                eq_seen_r <= 1'b0;
            end else if (eq_fwd) begin
                eq_seen_r <= 1'b1;
            end
            REQ_DONE <= good_req;
            if (good_req) OBJ_CODE <= obj_r;
        end
    end

    // ==========================================================
    // property store; outside write wins over the clear at a request
    wire [3:0] dirty_set = PROP_WR ? 4'(4'h1 << PROP_IDX) : 4'h0;
    wire [3:0] dirty_clr = good_req ? 4'hF : 4'h0;
    wire [3:0] dirty_nxt = (dirty_r & ~dirty_clr) | dirty_set;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            dirty_r <= 4'h0;
            snap_dirty_r <= 4'h0;
        end else begin
            dirty_r <= dirty_nxt;
            if (good_req) snap_dirty_r <= dirty_r;
        end
    end

    // value table with its frozen copy
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < `AAC_NPROP; i++) begin
                prop_val_r[i] <= 8'h00;
                snap_val_r[i] <= 8'h00;
            end
        end else begin
            if (PROP_WR) prop_val_r[PROP_IDX] <= PROP_DATA;
            if (good_req) begin
                for (int i = 0; i < `AAC_NPROP; i++) begin
                    snap_val_r[i] <= prop_val_r[i];
                end
            end
        end
    end

    // number of set bits
    function automatic logic [2:0] ones(input logic [3:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 4; i++) begin
            n = n + {2'h0, v[i]};
        end
        return n;
    endfunction

    // ==========================================================
    // response length and per-entry byte selection
    wire [2:0] n_dirty = ones(snap_dirty_r);
    wire [15:0] dl_tx = rsp_r.is_err ? 16'h0000 :
        rsp_r.incl ? `AAC_DL_FULL + {13'h0000, n_dirty} : `AAC_DL_RESULT;
    wire [7:0] or_chain [`AAC_NPROP+1];
    assign or_chain[0] = 8'h00;

    genvar k;
    generate
        for (k = 0; k < `AAC_NPROP; k++) begin : g_ent
            localparam logic [4:0] BASE = 5'(`AAC_IDX_ENT + 3 * k);
            localparam logic [31:0] CODES = `AAC_PROP_CODES;
            wire [7:0] code = CODES[31-8*k -: 8];
            wire [2:0] pos = ones(snap_dirty_r & 4'((5'h01 << k) - 5'h01));
            wire [7:0] ent = (tx_idx_r == BASE) ? `AAC_ENTRY_SIZE :
                (tx_idx_r == BASE + 5'h01) ? code :
                (tx_idx_r == BASE + 5'h02) ? snap_val_r[k] : 8'h00;
            wire [7:0] lst = (snap_dirty_r[k]
                && tx_idx_r == `AAC_IDX_LIST + {2'h0, pos}) ? code : 8'h00;
            assign or_chain[k+1] = or_chain[k] | ent | lst;
        end
    endgenerate

    // ==========================================================
    // transmit byte selection
    wire [15:0] ft_tx = rsp_r.is_err ? `AAC_FT_ERR : `AAC_FT_CMD;
    wire [7:0] cn_tx = rsp_r.is_err ? rsp_r.code : `AAC_CN_RSP;
    wire [7:0] tx_sel = (tx_idx_r == total_r - 5'h01) ? tx_chk :
        (tx_idx_r == 5'h00) ? `AAC_START :
        (tx_idx_r == `AAC_IDX_FT_HI) ? ft_tx[15:8] :
        (tx_idx_r == `AAC_IDX_FT_LO) ? ft_tx[7:0] :
        (tx_idx_r == `AAC_IDX_CN) ? cn_tx :
        (tx_idx_r == `AAC_IDX_FN) ? rsp_r.fn :
        (tx_idx_r == `AAC_IDX_DL_HI) ? dl_tx[15:8] :
        (tx_idx_r == `AAC_IDX_DL_LO) ? dl_tx[7:0] :
        (tx_idx_r == `AAC_IDX_RES_HI) ? rsp_r.result[15:8] :
        (tx_idx_r == `AAC_IDX_RES_LO) ? rsp_r.result[7:0] :
        (tx_idx_r == `AAC_IDX_CNT) ? {5'h00, n_dirty} :
        or_chain[`AAC_NPROP];
    wire tx_adv = tx_busy_r && (!tx_valid_r || TX_READY);
    // length settles while index 0 loads, so index 0 never waits on it
    wire tx_load = tx_adv && (tx_idx_r == 5'h00 || tx_idx_r < total_r);
    wire tx_sum_en = tx_load && tx_idx_r != 5'h00 && tx_idx_r != total_r - 5'h01;

    // ==========================================================
    // transmit sequencer; receive stalls while a frame goes out
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            tx_busy_r <= 1'b0;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_idx_r <= 5'h00;
            total_r <= 5'h00;
            rsp_r <= '0;
        end else if (frame_end) begin
            tx_busy_r <= 1'b1;
            tx_idx_r <= 5'h00;
            rsp_r.is_err <= err_go;
            rsp_r.code <= err_code;
            rsp_r.fn <= fn_r;
            rsp_r.result <= result;
            rsp_r.incl <= good_req && incl;
        end else if (tx_load) begin
            tx_data_r <= tx_sel;
            tx_valid_r <= 1'b1;
            tx_idx_r <= tx_idx_r + 5'h01;
        end else if (tx_adv) begin
            tx_valid_r <= 1'b0;
            tx_busy_r <= 1'b0;
        end
        if (!SYS_RST && tx_busy_r && tx_idx_r == 5'h00) begin
            total_r <= `AAC_FRAME_OVH + dl_tx[4:0];
        end
    end

    // transmit check byte
    aac_check_acc u_tx_chk (
        .clk(MCLK),
        .rst(SYS_RST),
        .clr(frame_end),
        .en(tx_sum_en),
        .data(tx_sel),
        .chk(tx_chk)
    );

    assign RX_READY = !tx_busy_r;
    assign TX_VALID = tx_valid_r;
    assign TX_DATA = tx_data_r;
    assign DIRTY = dirty_r;

endmodule

`default_nettype wire

// File: rtl/aac_consts.svh
// constants of the adapter access frame codec: field codes, results, error codes, layout
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH

// ==========================================================
// frame header fields
`define AAC_START 8'h02
`define AAC_FT_CMD 16'h0003
`define AAC_FT_ERR 16'h00FF
`define AAC_CN_REQ 8'h23
`define AAC_CN_RSP 8'hA3

// ==========================================================
// access codes carried in the first request data byte
`define AAC_ACC_RD 8'h00
`define AAC_ACC_WR 8'h01

// ==========================================================
// result codes
`define AAC_RES_OK 16'h0000
`define AAC_RES_OK_NET 16'h0001
`define AAC_RES_REJ 16'h0011
`define AAC_RES_ST_UNCONF 16'h0101
`define AAC_RES_ST_STANDBY 16'h0103
`define AAC_RES_ST_CONSTR 16'h0104
`define AAC_RES_ST_ERRSTOP 16'h0105
`define AAC_RES_OTHER 16'hFFFF

// ==========================================================
// error notification codes
`define AAC_ERR_CHK 8'h00
`define AAC_ERR_CMD 8'h01
`define AAC_ERR_RES 8'h02
`define AAC_ERR_FMT 8'h03
`define AAC_ERR_OTHER 8'hFF

// ==========================================================
// request body layout
`define AAC_BODY_ACC 16'h0000
`define AAC_BODY_OBJ_LAST 16'h0003
`define AAC_BODY_MIN 16'h0004

// ==========================================================
// adapter-owned property table, index 0 holds the highest code
`define AAC_NPROP 4
`define AAC_PROP_CODES 32'hB3B2B1B0
`define AAC_ENTRY_SIZE 8'h02

// ==========================================================
// transmit byte positions and lengths
`define AAC_IDX_FT_HI 5'h01
`define AAC_IDX_FT_LO 5'h02
`define AAC_IDX_CN 5'h03
`define AAC_IDX_FN 5'h04
`define AAC_IDX_DL_HI 5'h05
`define AAC_IDX_DL_LO 5'h06
`define AAC_IDX_RES_HI 5'h07
`define AAC_IDX_RES_LO 5'h08
`define AAC_IDX_ENT 5'h09
`define AAC_IDX_CNT 5'h15
`define AAC_IDX_LIST 5'h16
`define AAC_FRAME_OVH 5'h08
`define AAC_DL_RESULT 16'h0002
`define AAC_DL_FULL 16'h000F

`endif

// File: rtl/aac_pkg.sv
// types shared by the adapter access frame codec
package aac_pkg;

    // ==========================================================
    // receive parser states
    typedef enum logic [3:0] {
        RX_HUNT,
        RX_FT_HI,
        RX_FT_LO,
        RX_CN,
        RX_FN,
        RX_DL_HI,
        RX_DL_LO,
        RX_BODY,
        RX_CHK
    } aac_rx_e;

    // ==========================================================
    // context of the frame being sent
    typedef struct packed {
        logic is_err;          // error notification instead of response
        logic [7:0] code;      // error code for notifications
        logic [7:0] fn;        // function number echoed
        logic [15:0] result;   // result field of a response
        logic incl;            // property values, count and list present
    } aac_rsp_s;

    // a byte with its strobe
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } aac_byte_s;

endpackage

// File: rtl/aac_check_acc.sv
// running check byte: two's complement of the byte sum
`timescale 1ns/10ps
`default_nettype none

module aac_check_acc (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [7:0] chk
);
    import aac_pkg::*;

    logic [7:0] sum_r; // byte sum modulo 256

    // ==========================================================
    // accumulate; clear restarts a frame
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            sum_r <= 8'h00;
        end else if (en) begin
            sum_r <= sum_r + data;
        end
    end

    // check byte makes the whole sum zero
    assign chk = 8'(~sum_r + 8'h01);

endmodule

`default_nettype wire

// File: bench/aac_frame_codec_monitor.sv
// concurrent checks on the ports of the adapter access frame codec
`timescale 1ns/10ps
`default_nettype none
`include "aac_consts.svh"

module aac_frame_codec_monitor (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_ERR,
    input wire logic RX_READY,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire logic [15:0] ADAPTER_RESULT,
    input wire logic PROP_WR,
    input wire logic [1:0] PROP_IDX,
    input wire logic [7:0] PROP_DATA,
    input wire aac_pkg::aac_byte_s EQ_BYTE,
    input wire logic EQ_COMMIT,
    input wire logic EQ_ABORT,
    input wire logic [23:0] OBJ_CODE,
    input wire logic REQ_DONE,
    input wire logic [3:0] DIRTY
);
    import aac_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    // ==========================================================
    // helper logic
    logic [3:0] wmask_r; // index written at the previous edge
    // remember which property was written at the last edge
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wmask_r <= 4'h0;
        end else begin
            wmask_r <= PROP_WR ? (4'h1 << PROP_IDX) : 4'h0;
        end
    end

    // ==========================================================
    // sequences and properties
    sequence s_tx_open;
        TX_VALID && TX_DATA == `AAC_START;
    endsequence
    sequence s_req_end;
        REQ_DONE && !RX_READY;
    endsequence

    a_done_tx_open: assert property (s_req_end |=> s_tx_open) else $error("no answer after request");
    a_frame_open: assert property ($rose(TX_VALID) |-> TX_DATA == `AAC_START) else $error("bad start");
    a_tx_held: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA)) else $error("tx byte lost");
    a_rx_blocked: assert property (TX_VALID |-> !RX_READY) else $error("rx open while sending");
    a_done_rdy: assert property (REQ_DONE |-> !RX_READY) else $error("rx open at request end");
    a_dirty_set: assert property (PROP_WR |=> DIRTY[$past(PROP_IDX)]) else $error("dirty not set");
    a_dirty_clear: assert property (REQ_DONE |-> (DIRTY & ~wmask_r) == 4'h0) else $error("dirty kept");
    a_commit_excl: assert property (!(EQ_COMMIT && EQ_ABORT) && (!EQ_COMMIT || REQ_DONE)) else $error("commit with abort");
    a_obj_update: assert property ($changed(OBJ_CODE) |-> REQ_DONE) else $error("object code moved");
endmodule

bind aac_frame_codec aac_frame_codec_monitor u_mon (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_ERR(RX_ERR),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .ADAPTER_RESULT(ADAPTER_RESULT), .PROP_WR(PROP_WR), .PROP_IDX(PROP_IDX),
    .PROP_DATA(PROP_DATA), .EQ_BYTE(EQ_BYTE), .EQ_COMMIT(EQ_COMMIT), .EQ_ABORT(EQ_ABORT),
    .OBJ_CODE(OBJ_CODE), .REQ_DONE(REQ_DONE), .DIRTY(DIRTY)
);
`default_nettype wire

// File: bench/aac_eq_model.sv
// equipment side sink: takes answer frames, stalling at random when asked
`timescale 1ns/10ps
`default_nettype none

module aac_eq_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic stall,
    output logic tx_ready
);
    logic [7:0] q[$]; // bytes accepted so far
    initial tx_ready = 1'b0;
    // ready moves only after the falling edge
    always @(negedge mclk) begin
        tx_ready <= !rst && (!stall || $urandom_range(0, 2) != 0);
    end
    // keep every byte handed over at a rising edge
    always @(posedge mclk) begin
        if (!rst && tx_valid && tx_ready) begin
            q.push_back(tx_data);
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench of the adapter access frame codec
`timescale 1ns/10ps
`default_nettype none
`include "aac_consts.svh"

module tb_top;
    import aac_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, rx_valid = 1'b0, rx_err = 1'b0, prop_wr = 1'b0;
    logic stall = 1'b0;
    logic [7:0] rx_data = 8'h00, prop_data = 8'h00, fn = 8'h00;
    logic [1:0] prop_idx = 2'h0;
    logic [15:0] adapter_result = 16'h0000;
    wire logic rx_ready, tx_valid, tx_ready, eq_commit, eq_abort, req_done;
    wire logic [7:0] tx_data;
    wire logic [23:0] obj_code;
    wire logic [3:0] dirty;
    aac_byte_s eq_byte;
    int fail_count = 0, n_tests = 0, cyc = 0, n_eq = 0, n_commit = 0, n_done = 0, n_abort = 0;
    logic [7:0] vals[4]; // expected property values
    logic [3:0] dmod = 4'h0; // expected dirty bits
    logic [7:0] fr[$], bd[$], ex[$]; // request, body, expected answer

    aac_frame_codec uut (.MCLK(mclk), .SYS_RST(sys_rst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .RX_ERR(rx_err), .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_READY(tx_ready), .ADAPTER_RESULT(adapter_result), .PROP_WR(prop_wr),
        .PROP_IDX(prop_idx), .PROP_DATA(prop_data), .EQ_BYTE(eq_byte), .EQ_COMMIT(eq_commit),
        .EQ_ABORT(eq_abort), .OBJ_CODE(obj_code), .REQ_DONE(req_done), .DIRTY(dirty));
    aac_eq_model eq (.mclk(mclk), .rst(sys_rst), .tx_valid(tx_valid), .tx_data(tx_data),
        .stall(stall), .tx_ready(tx_ready));

    // ==========================================================
    // clock, pulse counters and hang guard
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        n_eq += (eq_byte.valid === 1'b1);
        n_commit += (eq_commit === 1'b1);
        n_done += (req_done === 1'b1);
        n_abort += (eq_abort === 1'b1);
        if (cyc == 30000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // helpers
    task automatic end_of_test;
        $display("mismatches %0d of %0d comparisons", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] csum(input logic [7:0] q[$]);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 1; i < q.size(); i++) s += q[i];
        return -s;
    endfunction
    function automatic logic res_ok(input logic [15:0] r);
        return r inside {16'h0000, 16'h0001, 16'h0011, 16'h0101, 16'h0103, 16'h0104, 16'h0105,
            16'hFFFF};
    endfunction
    // offer one byte and hold it until an edge takes it
    task automatic put(input logic [7:0] b);
        @(negedge mclk);
        while (rx_ready !== 1'b1) begin
            rx_valid = 1'b0;
            @(negedge mclk);
        end
        rx_valid = 1'b1;
        rx_data = b;
        @(posedge mclk);
    endtask
    // outside write of one adapter-owned property
    task automatic pw(input logic [1:0] idx, input logic [7:0] v);
        @(negedge mclk);
        prop_wr = 1'b1;
        prop_idx = idx;
        prop_data = v;
        vals[idx] = v;
        dmod[idx] = 1'b1;
        @(negedge mclk);
        prop_wr = 1'b0;
    endtask
    // send header, body and check byte; cut > 0 breaks off with a fault
    task automatic send(input logic [15:0] ft, input logic [7:0] cn, input logic bad, input int cut);
        fr = {`AAC_START, ft[15:8], ft[7:0], cn, fn, 8'(bd.size() >> 8), 8'(bd.size())};
        fr = {fr, bd};
        fr.push_back(csum(fr) + 8'(bad));
        for (int i = 0; i < (cut > 0 ? cut : fr.size()); i++) put(fr[i]);
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_err = (cut > 0);
        @(negedge mclk);
        rx_err = 1'b0;
    endtask
    task automatic expect_frame;
        int k;
        k = 0;
        while ((eq.q.size() < ex.size() || rx_ready !== 1'b1) && k < 400) begin
            @(negedge mclk);
            k++;
        end
        chk("frame length", 24'(eq.q.size()), 24'(ex.size()));
        foreach (ex[i]) chk("frame byte", eq.q[i], ex[i]);
        eq.q.delete();
    endtask

    // ==========================================================
    // object access request and its expected response
    task automatic access(input logic [7:0] acc, input int nd, input logic [15:0] res);
        logic [15:0] r, dl;
        logic [23:0] obj;
        logic incl;
        int e0, c0, d0, a0;
        obj = 24'($urandom);
        fn = 8'($urandom);
        bd = {acc, obj[23:16], obj[15:8], obj[7:0]};
        repeat (nd) bd.push_back(8'($urandom));
        @(negedge mclk);
        adapter_result = res;
        r = (acc > 8'h01) ? 16'h0011 : (res_ok(res) ? res : 16'hFFFF);
        incl = (r <= 16'h0001) && (acc == 8'h00);
        dl = incl ? 16'(15 + $countones(dmod)) : 16'h0002;
        e0 = n_eq;
        c0 = n_commit;
        a0 = n_abort;
        d0 = n_done;
        send(`AAC_FT_CMD, `AAC_CN_REQ, 1'b0, 0);
        ex = {8'h02, 8'h00, 8'h03, 8'hA3, fn, dl[15:8], dl[7:0], r[15:8], r[7:0]};
        if (incl) begin
            for (int i = 0; i < 4; i++) ex = {ex, 8'h02, 8'(8'hB3 - i), vals[i]};
            ex.push_back(8'($countones(dmod)));
            for (int i = 0; i < 4; i++) if (dmod[i]) ex.push_back(8'(8'hB3 - i));
        end
        ex.push_back(csum(ex));
        expect_frame();
        dmod = 4'h0;
        chk("object code", obj_code, obj);
        chk("request done", 24'(n_done - d0), 24'h1);
        chk("equipment bytes", 24'(n_eq - e0), (acc == 8'h01) ? 24'(nd) : 24'h0);
        chk("commit", 24'(n_commit - c0), 24'(acc == 8'h01 && r <= 16'h0001));
        chk("abort", 24'(n_abort - a0), 24'(acc == 8'h01 && nd > 0 && r > 16'h0001));
        if (nd > 0) chk("equipment data", eq_byte.data, bd[bd.size() - 1]);
        chk("dirty cleared", dirty, 24'h0);
    endtask
    // faulty request answered by an error notification
    task automatic err_case(input logic [15:0] ft, input logic [7:0] cn, input logic [7:0] acc,
        input int nb, input logic bad, input int cut, input logic [7:0] code);
        int d0;
        bd = {acc};
        repeat (nb - 1) bd.push_back(8'($urandom));
        fn = 8'($urandom);
        d0 = n_done;
        send(ft, cn, bad, cut);
        ex = {8'h02, 8'h00, 8'hFF, code, fn, 8'h00, 8'h00};
        ex.push_back(csum(ex));
        expect_frame();
        chk("done on error", 24'(n_done - d0), 24'h0);
        chk("dirty kept", dirty, dmod);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [15:0] rt[9];
        int s;
        rt = '{`AAC_RES_OK, `AAC_RES_OK_NET, `AAC_RES_REJ, `AAC_RES_ST_UNCONF, `AAC_RES_ST_STANDBY,
            `AAC_RES_ST_CONSTR, `AAC_RES_ST_ERRSTOP, `AAC_RES_OTHER, 16'h0222};
        s = $urandom(32'h8149);
        vals = '{default: 8'h00};
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        chk("dirty after reset", dirty, 24'h0);
        put(8'h55);
        foreach (rt[k]) begin
            repeat ($urandom_range(0, 3)) pw(2'($urandom_range(0, 3)), 8'($urandom));
            chk("dirty bits", dirty, dmod);
            stall = k[0];
            access(`AAC_ACC_RD, 0, rt[k]);
        end
        access(`AAC_ACC_WR, 1 + $urandom_range(0, 6), `AAC_RES_OK);
        access(`AAC_ACC_WR, 0, `AAC_RES_OK_NET);
        access(`AAC_ACC_WR, 3, `AAC_RES_REJ);
        access(8'h02, 0, `AAC_RES_OK);
        access(8'($urandom_range(3, 254)), 0, `AAC_RES_OK);
        access(8'hFF, 0, `AAC_RES_OK);
        pw(2'h3, 8'($urandom));
        err_case(`AAC_FT_CMD, `AAC_CN_REQ, 8'h00, 4, 1'b1, 0, `AAC_ERR_CHK);
        err_case(`AAC_FT_CMD, 8'h22, 8'h00, 4, 1'b0, 0, `AAC_ERR_CMD);
        err_case(16'h0004, `AAC_CN_REQ, 8'h00, 4, 1'b0, 0, `AAC_ERR_CMD);
        err_case(`AAC_FT_CMD, `AAC_CN_REQ, 8'h00, 5, 1'b0, 0, `AAC_ERR_FMT);
        err_case(`AAC_FT_CMD, `AAC_CN_REQ, 8'h01, 3, 1'b0, 0, `AAC_ERR_FMT);
        err_case(`AAC_FT_CMD, `AAC_CN_REQ, 8'h00, 4, 1'b0, 5, `AAC_ERR_OTHER);
        access(`AAC_ACC_RD, 0, `AAC_RES_OK);
        end_of_test();
    end
endmodule
`default_nettype wire
